// file: core/epm_pkg.sv
/*
 * Constants for the enclave perfmon suppression block: register map,
 * field positions, reset values and counter layout.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package epm_pkg;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] EPM_OFF_CTRL     = 8'h00;
    localparam logic [7:0] EPM_OFF_ALLTHR   = 8'h04;
    localparam logic [7:0] EPM_OFF_GSTAT_LO = 8'h08;
    localparam logic [7:0] EPM_OFF_GSTAT_HI = 8'h0C;
    localparam logic [7:0] EPM_OFF_ENTRY_LO = 8'h10;
    localparam logic [7:0] EPM_OFF_ENTRY_HI = 8'h14;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int EPM_CTRL_PREC_BIT   = 16;  // Precise sampling enable
    localparam int EPM_CTRL_SHARED_BIT = 17;  // Shared counter enable
    localparam int EPM_ASC_BIT         = 60;  // Anti-side-channel flag
    localparam int EPM_ASC_HI_BIT      = EPM_ASC_BIT - 32;
    localparam int EPM_ST_INENC_BIT    = 0;
    localparam int EPM_ST_DEBUG_BIT    = 1;
    localparam int EPM_ST_SIB_BIT      = 2;
    localparam int EPM_ST_TRAP_BIT     = 3;
    localparam int EPM_ST_WIN_BIT      = 4;

    // Counter vector layout: fixed zero, two cycle counters, generals
    localparam int EPM_FIX0   = 0;
    localparam int EPM_FIX1   = 1;
    localparam int EPM_FIX2   = 2;
    localparam int EPM_GP_LSB = 3;

    // ****************************************************************
    // Reset values and bus answers
    // ****************************************************************
    localparam logic [31:0] EPM_CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] EPM_ALLTHR_RST = 32'h0000_0000;
    localparam logic [1:0]  EPM_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  EPM_RESP_SLV   = 2'h2;

    // Kind of user/supervisor enclave leaf ending
    localparam logic [1:0] EPM_LEAF_SUPER  = 2'h0;  // Any supervisor leaf
    localparam logic [1:0] EPM_LEAF_KEYREP = 2'h1;  // Key derive or report
    localparam logic [1:0] EPM_LEAF_OTHER  = 2'h3;

    // Per-thread enclave state, one-hot
    typedef enum logic [3:0] {
        EPM_ST_OUT  = 4'h1,
        EPM_ST_DBG  = 4'h2,
        EPM_ST_PROT = 4'h4,
        EPM_ST_AEXW = 4'h8
    } epm_state_e;

endpackage : epm_pkg

// file: core/epm_core.sv
/*
 * Enclave perfmon suppression for one hardware thread: gates counters and
 * precise sample records around enclave entries and exits, keeps the
 * anti-side-channel flag, picks the eventing address, and steers buffer
 * faults raised while records are written at an async enclave exit.
 * Assumes the core gives one-cycle event pulses synchronous to I_CLK and
 * holds the sibling-thread level stable while it is valid.
 */
// The AXI4-Lite register port and the address map were chosen for this implementation.
// Function
// - Debug entry: count normally, flag stays clear
// - Non-debug entry: stop all but cycle counters
// - Non-debug entry: suppress precise sample records
// - Non-debug entry: set anti-side-channel flag bit 60
// - Sibling protected: all-threads counters count own thread
// - Exit or async exit: resume suppressed counting
// - Exit: restore sibling all-threads counting
// - Leaf end record reports leaf address
// - Enter/resume record only on debug entry
// - Normal exit record address by entry type
// - Async exit record holds synthetic state, address
// - Second record after event delivery reports entry point
// - Buffer fault outside window: report, skip record
// - Buffer fault in async window: drop, abort
// - Buffer trap in window: pend to boundary
// - After abort, continue delivering exit event
// - Debug mode: transitions count far branch, instruction
// - Non-debug: whole enclave counts once each
// - Shared counters unaffected by entry
// - Flag clear means counters accumulate normally
`timescale 1ns/100ps
module epm_core
    import epm_pkg::*;
#(
    parameter int NUM_GP = 4,   // General counters
    parameter int AW     = 64   // Linear address width
) (
    input  wire logic                I_CLK,          // Core clock
    input  wire logic                I_RST_B,        // Sync reset, low
    input  wire logic [7:0]          I_AWADDR,       // AXI write address
    input  wire logic                I_AWVALID,      // AXI
    output logic                     O_AWREADY,      // AXI
    input  wire logic [31:0]         I_WDATA,        // AXI write data
    input  wire logic [3:0]          I_WSTRB,        // AXI byte enables
    input  wire logic                I_WVALID,       // AXI
    output logic                     O_WREADY,       // AXI
    output logic [1:0]               O_BRESP,        // AXI
    output logic                     O_BVALID,       // AXI
    input  wire logic                I_BREADY,       // AXI
    input  wire logic [7:0]          I_ARADDR,       // AXI read address
    input  wire logic                I_ARVALID,      // AXI
    output logic                     O_ARREADY,      // AXI
    output logic [31:0]              O_RDATA,        // AXI
    output logic [1:0]               O_RRESP,        // AXI
    output logic                     O_RVALID,       // AXI
    input  wire logic                I_RREADY,       // AXI
    input  wire logic                I_ENTER,        // Enter/resume retires
    input  wire logic                I_ENTER_DEBUG,  // Entry permits debug
    input  wire logic [AW-1:0]       I_ENTER_ADDR,   // Enter/resume address
    input  wire logic                I_EXIT,         // Normal exit retires
    input  wire logic [AW-1:0]       I_EXIT_ADDR,    // Exit instr address
    input  wire logic                I_AEX,          // Async exit done
    input  wire logic [AW-1:0]       I_AEX_SAVED,    // Saved in-enclave addr
    input  wire logic [AW-1:0]       I_AEP_ADDR,     // Async entry point
    input  wire logic                I_LEAF_END,     // Other leaf retires
    input  wire logic [1:0]          I_LEAF_KIND,    // Leaf class
    input  wire logic [AW-1:0]       I_LEAF_ADDR,    // Leaf instr address
    input  wire logic                I_PREC_PEND,    // Precise event pending
    input  wire logic                I_EEE_DONE,     // Exit event delivered
    input  wire logic                I_REC_DONE,     // Record write finished
    input  wire logic                I_BUF_FAULT,    // Fault on buffer access
    input  wire logic                I_BUF_TRAP,     // Trap on buffer store
    input  wire logic                I_INSN_BOUND,   // Instruction boundary
    input  wire logic                I_SIB_PROT,     // Sibling non-debug in
    output logic [NUM_GP+2:0]        O_CNT_EN,       // Per-counter enable
    output logic [NUM_GP+2:0]        O_ALL_THR,      // Effective all-threads
    output logic                     O_SHARED_EN,    // Shared counter enable
    output logic                     O_PREC_EN,      // Precise sampling on
    output logic                     O_REC_REQ,      // Write a record, pulse
    output logic [AW-1:0]            O_REC_ADDR,     // Eventing address
    output logic                     O_REC_SYNTH,    // Record of synth state
    output logic                     O_FAULT_RPT,    // Report fault, pulse
    output logic                     O_REC_ABORT,    // Abort record, pulse
    output logic                     O_TRAP_FIRE,    // Deliver trap, pulse
    output logic                     O_EEE_GO,       // Continue exit event
    output logic                     O_BR_INC,       // Branch count +1
    output logic                     O_INS_INC,      // Instruction count +1
    output logic                     O_ASC_FLAG      // Anti-side-channel
);

    localparam int NC = NUM_GP + 3;

    // ****************************************************************
    // State
    // ****************************************************************
    epm_state_e          st_q, st_d;
    logic [31:0]         ctrl_q, allthr_q;
    logic                asc_q;
    logic                dbg_q;        // Type of last entry
    logic [AW-1:0]       entry_q;      // Address of last entry
    logic                trap_q;       // Trap held for boundary
    logic                eee_rec_q;    // Record after event delivery armed
    logic [NC-1:0]       cnt_en_q, allthr_eff_q;
    logic                prec_en_q, shared_q, rec_req_q, synth_q;
    logic [AW-1:0]       rec_addr_q;
    logic                fault_q, abort_q, trapf_q, eee_q, br_q, ins_q;

    // Pick the record address for a given entry type
    function automatic logic [AW-1:0] pick_addr(
        input logic          dbg,
        input logic [AW-1:0] dbg_addr,
        input logic [AW-1:0] ent_addr
    );
        pick_addr = dbg ? dbg_addr : ent_addr;
    endfunction : pick_addr

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    logic        awr_q, wr_q, arr_q, bv_q, rv_q, aw_have_q, w_have_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q, rresp_q;

    wire aw_hs     = I_AWVALID & awr_q;
    wire w_hs      = I_WVALID & wr_q;
    wire aw_have_n = aw_have_q | aw_hs;
    wire w_have_n  = w_have_q | w_hs;
    wire do_wr     = aw_have_n & w_have_n & ~bv_q;
    wire [7:0]  wa = aw_hs ? I_AWADDR : awaddr_q;
    wire [31:0] wd = w_hs ? I_WDATA : wdata_q;
    wire [3:0]  ws = w_hs ? I_WSTRB : wstrb_q;
    wire ar_hs     = I_ARVALID & arr_q;

    // Byte-lane merge for writes
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0]  be
    );
        for (int i = 0; i < 4; i++)
        begin
            merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    wire wr_ctrl   = do_wr & (wa == EPM_OFF_CTRL);
    wire wr_allthr = do_wr & (wa == EPM_OFF_ALLTHR);
    wire wr_hi     = do_wr & (wa == EPM_OFF_GSTAT_HI);
    wire wa_ok     = (wa == EPM_OFF_CTRL) | (wa == EPM_OFF_ALLTHR)
                   | (wa == EPM_OFF_GSTAT_HI) | (wa == EPM_OFF_GSTAT_LO);
    // Flag is write-one-to-clear in the upper status word
    wire asc_clr   = wr_hi & ws[EPM_ASC_HI_BIT/8] & wd[EPM_ASC_HI_BIT];

    // Read decode; unmapped offsets answer SLVERR with zero data
    wire [31:0] st_word = {27'h0, (st_q == EPM_ST_AEXW), trap_q, I_SIB_PROT,
                           dbg_q, (st_q != EPM_ST_OUT)};
    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb
    begin
        rd_ok  = 1'b1;
        unique case (I_ARADDR)
            EPM_OFF_CTRL:     rd_mux = ctrl_q;
            EPM_OFF_ALLTHR:   rd_mux = allthr_q;
            EPM_OFF_GSTAT_LO: rd_mux = st_word;
            EPM_OFF_GSTAT_HI: rd_mux = 32'(asc_q) << EPM_ASC_HI_BIT;
            EPM_OFF_ENTRY_LO: rd_mux = entry_q[31:0];
            EPM_OFF_ENTRY_HI: rd_mux = 32'(entry_q >> 32);
            default:
            begin
                rd_mux = 32'h0000_0000;
                rd_ok  = 1'b0;
            end
        endcase
    end

    // Bus handshake registers; one write and one read in flight
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_B)
        begin
            {awr_q, wr_q, arr_q} <= 3'h7;
            {bv_q, rv_q, aw_have_q, w_have_q} <= 4'h0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bresp_q  <= EPM_RESP_OKAY;
            rresp_q  <= EPM_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end
        else
        begin
            if (aw_hs) awaddr_q <= I_AWADDR;
            if (w_hs) wdata_q <= I_WDATA;
            if (w_hs) wstrb_q <= I_WSTRB;
            aw_have_q <= aw_have_n & ~do_wr;
            w_have_q  <= w_have_n & ~do_wr;
            awr_q     <= ~(aw_have_n & ~do_wr) & ~(do_wr | (bv_q & ~I_BREADY));
            wr_q      <= ~(w_have_n & ~do_wr) & ~(do_wr | (bv_q & ~I_BREADY));
            if (do_wr) bresp_q <= wa_ok ? EPM_RESP_OKAY : EPM_RESP_SLV;
            bv_q      <= do_wr | (bv_q & ~I_BREADY);
            if (ar_hs) rdata_q <= rd_mux;
            if (ar_hs) rresp_q <= rd_ok ? EPM_RESP_OKAY : EPM_RESP_SLV;
            rv_q      <= ar_hs | (rv_q & ~I_RREADY);
            arr_q     <= ~(ar_hs | (rv_q & ~I_RREADY));
        end
    end

    // ****************************************************************
    // Enclave state machine and entry latch
    // ****************************************************************
    wire in_prot = (st_q == EPM_ST_PROT);
    wire in_win  = (st_q == EPM_ST_AEXW);
    wire win_end = in_win & (I_REC_DONE | I_BUF_FAULT);

    // Next state: async exit with no record goes straight out
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            EPM_ST_OUT:
                if (I_ENTER) st_d = I_ENTER_DEBUG ? EPM_ST_DBG : EPM_ST_PROT;
            EPM_ST_DBG, EPM_ST_PROT:
                if (I_EXIT) st_d = EPM_ST_OUT;
                else if (I_AEX)
                    st_d = (I_PREC_PEND & ctrl_q[EPM_CTRL_PREC_BIT])
                         ? EPM_ST_AEXW : EPM_ST_OUT;
            EPM_ST_AEXW:
                if (win_end) st_d = EPM_ST_OUT;
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_B)
        begin
            st_q     <= EPM_ST_OUT;
            dbg_q    <= 1'b0;
            entry_q  <= '0;
            ctrl_q   <= EPM_CTRL_RST;
            allthr_q <= EPM_ALLTHR_RST;
            asc_q    <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            if (I_ENTER & (st_q == EPM_ST_OUT))
            begin
                dbg_q   <= I_ENTER_DEBUG;
                entry_q <= I_ENTER_ADDR;
            end
            if (wr_ctrl) ctrl_q <= merge(ctrl_q, wd, ws);
            if (wr_allthr) allthr_q <= merge(allthr_q, wd, ws);
            // Hardware set beats software clear in the same cycle
            if (I_ENTER & ~I_ENTER_DEBUG) asc_q <= 1'b1;
            else if (asc_clr) asc_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Counter gating and sibling demotion
    // ****************************************************************
    // Cycle counters keep running; everything else stops while protected
    logic [NC-1:0] keep_mask;
    always_comb
    begin
        keep_mask = '0;
        keep_mask[EPM_FIX1] = 1'b1;
        keep_mask[EPM_FIX2] = 1'b1;
    end
    wire [NC-1:0] sw_en  = ctrl_q[NC-1:0];
    wire [NC-1:0] en_d   = in_prot ? (sw_en & keep_mask) : sw_en;
    wire [NC-1:0] all_d  = I_SIB_PROT ? '0 : allthr_q[NC-1:0];
    wire          prec_d = ctrl_q[EPM_CTRL_PREC_BIT] & ~in_prot;

    // ****************************************************************
    // Precise record requests and eventing address
    // ****************************************************************
    wire prec_ok  = ctrl_q[EPM_CTRL_PREC_BIT] & I_PREC_PEND;
    wire in_enc   = (st_q == EPM_ST_DBG) | in_prot;
    wire rq_leaf  = I_LEAF_END & (I_LEAF_KIND != EPM_LEAF_OTHER) & ~in_prot;
    wire rq_enter = I_ENTER & I_ENTER_DEBUG & (st_q == EPM_ST_OUT);
    wire rq_exit  = I_EXIT & in_enc;
    wire rq_aex   = I_AEX & in_enc;
    wire rq_eee   = I_EEE_DONE & eee_rec_q;
    wire rec_go   = prec_ok & (rq_leaf | rq_enter | rq_exit | rq_aex | rq_eee);

    logic [AW-1:0] addr_d;
    always_comb
    begin
        if (rq_aex)
            addr_d = pick_addr(dbg_q, I_AEX_SAVED, entry_q);
        else if (rq_exit)
            addr_d = pick_addr(dbg_q, I_EXIT_ADDR, entry_q);
        else if (rq_enter)
            addr_d = I_ENTER_ADDR;
        else if (rq_eee)
            addr_d = I_AEP_ADDR;
        else
            addr_d = I_LEAF_ADDR;
    end

    // Enclave transitions as branches and instructions retired
    wire br_d = (dbg_q & in_enc & (I_EXIT | I_AEX))
              | rq_enter
              | (in_prot & (I_EXIT | I_AEX));

    // ****************************************************************
    // Output registers
    // ****************************************************************
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_B)
        begin
            cnt_en_q     <= '0;
            allthr_eff_q <= '0;
            prec_en_q    <= 1'b0;
            shared_q     <= 1'b0;
            rec_req_q    <= 1'b0;
            rec_addr_q   <= '0;
            synth_q      <= 1'b0;
            {fault_q, abort_q, trapf_q, eee_q} <= 4'h0;
            {br_q, ins_q, trap_q, eee_rec_q} <= 4'h0;
        end
        else
        begin
            cnt_en_q     <= en_d;
            allthr_eff_q <= all_d;
            prec_en_q    <= prec_d;
            shared_q     <= ctrl_q[EPM_CTRL_SHARED_BIT];
            rec_req_q    <= rec_go;
            if (rec_go) rec_addr_q <= addr_d;
            if (rec_go) synth_q <= rq_aex;
            // Outside the window a fault is reported and the record dropped
            fault_q <= I_BUF_FAULT & ~in_win;
            abort_q <= I_BUF_FAULT;
            // Exit event resumes once the record is written or aborted
            eee_q   <= win_end
                     | (I_AEX & in_enc & (st_d == EPM_ST_OUT));
            // Traps in the window wait for the next boundary
            if (I_BUF_TRAP & in_win) trap_q <= 1'b1;
            else if (I_INSN_BOUND) trap_q <= 1'b0;
            trapf_q <= (trap_q & I_INSN_BOUND)
                     | (I_BUF_TRAP & ~in_win);
            br_q  <= br_d;
            ins_q <= br_d;
            // A pending event after delivery reports the entry point
            if (I_AEX & in_enc) eee_rec_q <= 1'b1;
            else if (I_EEE_DONE | I_ENTER) eee_rec_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Port drive, all straight from flip-flops
    // ****************************************************************
    assign O_AWREADY   = awr_q;
    assign O_WREADY    = wr_q;
    assign O_BRESP     = bresp_q;
    assign O_BVALID    = bv_q;
    assign O_ARREADY   = arr_q;
    assign O_RDATA     = rdata_q;
    assign O_RRESP     = rresp_q;
    assign O_RVALID    = rv_q;
    assign O_CNT_EN    = cnt_en_q;
    assign O_ALL_THR   = allthr_eff_q;
    assign O_SHARED_EN = shared_q;
    assign O_PREC_EN   = prec_en_q;
    assign O_REC_REQ   = rec_req_q;
    assign O_REC_ADDR  = rec_addr_q;
    assign O_REC_SYNTH = synth_q;
    assign O_FAULT_RPT = fault_q;
    assign O_REC_ABORT = abort_q;
    assign O_TRAP_FIRE = trapf_q;
    assign O_EEE_GO    = eee_q;
    assign O_BR_INC    = br_q;
    assign O_INS_INC   = ins_q;
    assign O_ASC_FLAG  = asc_q;

endmodule : epm_core

// file: verif/epm_core_properties.sv
/* Checker for the enclave perfmon suppression core.
   Sees only core ports; bound from the bench top. */
`timescale 1ns/100ps
module epm_core_properties #(
    parameter int NUM_GP = 4,
    parameter int AW     = 64
) (
    input wire logic              I_CLK, I_RST_B, I_ENTER, I_ENTER_DEBUG, I_EXIT, I_AEX,
    input wire logic              I_EEE_DONE, I_SIB_PROT,
    input wire logic [AW-1:0]     I_AEP_ADDR,
    input wire logic [NUM_GP+2:0] O_CNT_EN, O_ALL_THR,
    input wire logic              O_SHARED_EN, O_PREC_EN, O_REC_REQ, O_FAULT_RPT,
    input wire logic              O_REC_ABORT, O_EEE_GO, O_BR_INC, O_INS_INC, O_ASC_FLAG,
    input wire logic [AW-1:0]     O_REC_ADDR
);
    // ****************************************************************
    // Enclave presence seen from the pulses
    // ****************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    logic in_q;
    wire  ent_nd = !in_q && I_ENTER && !I_ENTER_DEBUG;
    wire  ent_db = !in_q && I_ENTER && I_ENTER_DEBUG;
    // Re-entry while inside is ignored, so only the first entry counts
    always_ff @(posedge I_CLK)
    begin
        in_q <= !I_RST_B ? 1'b0 : I_ENTER ? 1'b1 : (I_EXIT | I_AEX) ? 1'b0 : in_q;
    end
    AST_ASC_SET: assert property (ent_nd |=> O_ASC_FLAG) else $error("flag not set");
    AST_ASC_DBG: assert property (ent_db && !O_ASC_FLAG |=> !O_ASC_FLAG)
        else $error("flag set on debug entry");
    AST_CNT_GATE: assert property (ent_nd |=> ##1 !O_CNT_EN[0] && O_CNT_EN[NUM_GP+2:3] == '0)
        else $error("counters not gated");
    AST_PREC_OFF: assert property (ent_nd |=> ##1 !O_PREC_EN) else $error("sampling on");
    AST_SIB_OWN: assert property (I_SIB_PROT |=> O_ALL_THR == '0) else $error("all thr");
    AST_DBG_BR: assert property (ent_db |=> O_BR_INC && O_INS_INC) else $error("no branch");
    AST_FLT_SKIP: assert property (O_FAULT_RPT |-> O_REC_ABORT) else $error("no skip");
    AST_ABORT_GO: assert property (O_REC_ABORT && !O_FAULT_RPT |-> O_EEE_GO)
        else $error("exit event stalled");
    AST_EEE_AEP: assert property (O_REC_REQ && $past(I_EEE_DONE) |->
        O_REC_ADDR == $past(I_AEP_ADDR)) else $error("eee address");
    AST_SHARED: assert property (I_ENTER |=> $stable(O_SHARED_EN)) else $error("shared");
    cover property (ent_nd);
    cover property (O_REC_ABORT && O_EEE_GO);
    cover property (I_SIB_PROT);
endmodule : epm_core_properties

// file: verif/epm_core_model.sv
/* Core retirement side: pulses enclave events one cycle wide.
   Caller enters tasks just after a rising clock edge. */
`timescale 1ns/100ps
module epm_core_model (
    input  wire logic i_clk,  // Core clock
    output logic [5:0] o_ev,  // Fault,leaf,eee,aex,exit,enter
    output logic       o_dbg, // Entry permits debug
    output logic       o_pend // Precise event pending
);
    initial
    begin
        o_ev = '0;
        o_dbg = 1'b0;
        o_pend = 1'b0;
    end
    // Pending drops after the event so no stale level leaks on
    task ev(input int k, input logic d, input logic p);
        o_ev[k] <= 1'b1;
        o_dbg <= d;
        o_pend <= p;
        @(posedge i_clk);
        o_ev <= '0;
        o_pend <= 1'b0;
        #1;
    endtask : ev
endmodule : epm_core_model

// file: verif/enclave_perfmon_suppression_tb.sv
/* Self-checking bench for epm_core; AXI4-Lite master and event driver.
   Assumes NUM_GP of 4 and 64-bit addresses. */
`timescale 1ns/100ps
module enclave_perfmon_suppression_tb
    import epm_pkg::*;
;
    logic I_CLK=0, I_RST_B=0, I_AWVALID=0, I_WVALID=0, I_BREADY=0, I_ARVALID=0, I_RREADY=0;
    logic I_REC_DONE=0, I_BUF_TRAP=0, I_INSN_BOUND=0, I_SIB_PROT=0;
    logic [7:0] I_AWADDR=0, I_ARADDR=0;
    logic [31:0] I_WDATA=0, O_RDATA, s=32'h8A620E91;
    logic [3:0] I_WSTRB=4'hF;
    logic [1:0] I_LEAF_KIND=0, O_BRESP, O_RRESP;
    logic [63:0] I_ENTER_ADDR=0, I_EXIT_ADDR=0, I_AEX_SAVED=0, I_AEP_ADDR=0, I_LEAF_ADDR=0, O_REC_ADDR, ent;
    logic I_ENTER, I_ENTER_DEBUG, I_EXIT, I_AEX, I_EEE_DONE, I_PREC_PEND, I_LEAF_END, I_BUF_FAULT;
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_SHARED_EN, O_PREC_EN, O_REC_REQ;
    logic O_REC_SYNTH, O_FAULT_RPT, O_REC_ABORT, O_TRAP_FIRE, O_EEE_GO, O_BR_INC, O_INS_INC;
    logic O_ASC_FLAG;
    logic [6:0] O_CNT_EN, O_ALL_THR;
    int errors = 0;
    int n_tests = 0;
    epm_core #(.NUM_GP(4), .AW(64)) DUT (.*);
    epm_core_model m (.i_clk(I_CLK), .o_dbg(I_ENTER_DEBUG), .o_pend(I_PREC_PEND),
        .o_ev({I_BUF_FAULT, I_LEAF_END, I_EEE_DONE, I_AEX, I_EXIT, I_ENTER}));
    always #10 I_CLK = ~I_CLK;
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task rnd;
        s = lfsr(s);
        I_ENTER_ADDR <= {s, ~s};
        I_EXIT_ADDR <= {~s, s};
        s = lfsr(s);
        I_AEX_SAVED <= {s, s};
        I_AEP_ADDR <= {~s, ~s};
        I_LEAF_ADDR <= {s, s ^ 32'h5};
    endtask : rnd
    task chk(input string n, input logic [71:0] e, input logic [71:0] g);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task cyc;
        @(posedge I_CLK);
        #1;
    endtask : cyc
    // Write: address and data offered together, each dropped when taken
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        I_AWADDR <= a; I_WDATA <= d; I_AWVALID <= 1'b1; I_WVALID <= 1'b1; I_BREADY <= 1'b1;
        do
        begin
            @(posedge I_CLK);
            if (O_AWREADY) aw = 1'b0;
            if (O_WREADY) w = 1'b0;
            I_AWVALID <= aw;
            I_WVALID <= w;
        end while (aw | w);
        do @(posedge I_CLK); while (!O_BVALID);
        chk("bresp", r, O_BRESP);
        I_BREADY <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        I_ARADDR <= a; I_ARVALID <= 1'b1; I_RREADY <= 1'b1;
        do @(posedge I_CLK); while (!O_ARREADY);
        I_ARVALID <= 1'b0;
        do @(posedge I_CLK); while (!O_RVALID);
        chk("rdata", {d, r}, {O_RDATA, O_RRESP});
        I_RREADY <= 1'b0;
        #1;
    endtask : rd
    task results;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // ****************************************************************
    // Scenarios; watchdog allows about fifty times the expected run
    // ****************************************************************
    initial
    begin
        #40000;
        errors++;
        results;
    end
    initial
    begin
        repeat (2) @(posedge I_CLK);
        I_RST_B <= 1'b1;
        #1;
        wr(EPM_OFF_CTRL, 32'h0003_007F, EPM_RESP_OKAY);
        wr(EPM_OFF_ALLTHR, 32'h0000_007F, EPM_RESP_OKAY);
        rd(EPM_OFF_CTRL, 32'h0003_007F, EPM_RESP_OKAY);
        rd(8'h20, 32'h0, EPM_RESP_SLV);
        wr(EPM_OFF_ENTRY_LO, 32'h1, EPM_RESP_SLV);
        rnd; m.ev(0, 1, 1);
        chk("dbg_ent", {1'b1, I_ENTER_ADDR, 3'b110}, {O_REC_REQ, O_REC_ADDR, O_BR_INC, O_INS_INC, O_ASC_FLAG});
        cyc; chk("cnt_en", 7'h7F, O_CNT_EN);
        rnd; m.ev(1, 1, 1); chk("dbg_exit", {1'b1, I_EXIT_ADDR}, {O_REC_REQ, O_REC_ADDR});
        rnd; m.ev(0, 0, 1); ent = I_ENTER_ADDR;
        chk("prot_ent", 2'b01, {O_REC_REQ, O_ASC_FLAG});
        cyc; chk("gate", 9'h19, {O_CNT_EN, O_PREC_EN, O_SHARED_EN});
        rd(EPM_OFF_GSTAT_HI, 32'h1000_0000, EPM_RESP_OKAY);
        rd(EPM_OFF_ENTRY_LO, ent[31:0], EPM_RESP_OKAY);
        I_SIB_PROT <= 1'b1; cyc; cyc; chk("all_thr", 7'h00, O_ALL_THR);
        I_SIB_PROT <= 1'b0; cyc; cyc; chk("all_thr", 7'h7F, O_ALL_THR);
        rnd; m.ev(1, 0, 1); chk("exit", {1'b1, ent, 2'b11}, {O_REC_REQ, O_REC_ADDR, O_BR_INC, O_INS_INC});
        cyc; chk("resume", 8'hFF, {O_CNT_EN, O_PREC_EN});
        rnd; m.ev(0, 0, 0); ent = I_ENTER_ADDR; rnd; m.ev(2, 0, 1);
        chk("aex", {1'b1, ent, 1'b1}, {O_REC_REQ, O_REC_ADDR, O_REC_SYNTH});
        m.ev(5, 0, 0); chk("abort", 3'b101, {O_REC_ABORT, O_FAULT_RPT, O_EEE_GO});
        m.ev(3, 0, 1); chk("eee", {1'b1, I_AEP_ADDR}, {O_REC_REQ, O_REC_ADDR});
        for (int k = 0; k < 2; k++)
        begin
            I_LEAF_KIND <= k[1:0]; rnd; m.ev(4, 0, 1);
            chk("leaf", {1'b1, I_LEAF_ADDR}, {O_REC_REQ, O_REC_ADDR});
        end
        rnd; m.ev(0, 0, 0); m.ev(4, 0, 1); chk("leaf_prot", 1'b0, O_REC_REQ);
        m.ev(2, 0, 1); I_BUF_TRAP <= 1'b1; cyc; chk("trap_hold", 1'b0, O_TRAP_FIRE);
        I_BUF_TRAP <= 1'b0; I_REC_DONE <= 1'b1; cyc; I_REC_DONE <= 1'b0;
        chk("rec_done", 2'b10, {O_EEE_GO, O_TRAP_FIRE});
        I_INSN_BOUND <= 1'b1; cyc; I_INSN_BOUND <= 1'b0; chk("trap", 1'b1, O_TRAP_FIRE);
        m.ev(5, 0, 0); chk("fault", 2'b11, {O_FAULT_RPT, O_REC_ABORT});
        results;
    end
endmodule : enclave_perfmon_suppression_tb
bind epm_core epm_core_properties #(.NUM_GP(NUM_GP), .AW(AW)) u_chk (.*);
